// >>> rtl/uesf_consts.svh
// Purpose: offsets, field positions and reset values of the endpoint status flag block
// Assumes: byte-wide register port, endpoint number selects the register view
// Notes:   definitions only
`ifndef UESF_CONSTS_SVH
`define UESF_CONSTS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define UESF_OFS_SELECTOR     8'hc7
`define UESF_OFS_STATUS       8'hce
`define UESF_OFS_BYTE_LOW     8'he2
`define UESF_OFS_BYTE_HIGH    8'he3
`define UESF_OFS_IRQ_FLAGS    8'hf8
`define UESF_OFS_IRQ_ENABLE   8'hc2
`define UESF_OFS_EP_CONFIG    8'hd4

// ************************************************************
// status bit positions
// ************************************************************
`define UESF_BIT_DIR          7
`define UESF_BIT_OUT_B1       6
`define UESF_BIT_STALL_RQ     5
`define UESF_BIT_IN_READY     4
`define UESF_BIT_STL_CRC      3
`define UESF_BIT_SETUP        2
`define UESF_BIT_OUT_B0       1
`define UESF_BIT_IN_DONE      0

// ************************************************************
// reset values and sizes
// ************************************************************
`define UESF_STATUS_RESET     8'h00
`define UESF_COUNT_RESET      11'h000
`define UESF_EP_COUNT         8
`define UESF_EP_BITS          3
`define UESF_SELECTOR_MASK    8'h07
`define UESF_SF_MASK          8'h4f

`endif

// >>> rtl/uesf_count_mem.sv
// Purpose: per-endpoint store of the received byte count
// Assumes: one write port, one registered read port
// Notes:   read data appear one cycle after the address
`timescale 1ns/1ps
`include "uesf_consts.svh"

module uesf_count_mem (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              wr_en_in,
  input  wire logic [2:0]        wr_addr_in,
  input  wire logic [10:0]       wr_data_in,
  input  wire logic [2:0]        rd_addr_in,
  output logic      [10:0]       rd_data_out
);

  logic [10:0] mem_ff [`UESF_EP_COUNT];

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int i = 0; i < `UESF_EP_COUNT; i++) begin
        mem_ff[i] <= `UESF_COUNT_RESET;
      end
      rd_data_out <= `UESF_COUNT_RESET;
    end else begin
      if (wr_en_in) begin
        mem_ff[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem_ff[rd_addr_in];
    end
  end

endmodule // uesf_count_mem

// >>> rtl/uesf_flags.sv
// Functional notes
// - control endpoints: status bit 7 holds data/status stage direction, firmware owned
// - stall request bit 5 makes the endpoint answer with a stall handshake
// - hardware clears bit 4 on send (iso) or host ack, raising interrupt
// - non-iso: bit 3 set after a requested stall was sent, interrupt raised
// - iso: bit 3 read only, crc error of last data, refreshed each packet
// - valid setup sets bit 2, clears all other bits, raises interrupt
// - bit 1 set when out packet stored in bank 0, interrupt raised
// - while bank 0 flag set, out to bank 0 is nak'ed except iso
// - control endpoints: setup may overwrite fifo while out flag set
// - bank 1 flag in bit 6 behaves like bank 0
// - bit 0 set on host ack of in packet (non-iso), interrupt raised
// - events raise endpoint flag in read-only register whether enabled or not; enable gates only the interrupt line
// - byte count high register holds count bits 10 to 8
// - reserved high bits of byte count high read as zero
// - byte count low register holds count bits 7 to 0
// - status and byte count registers follow the selected endpoint number
//
// Purpose: endpoint status and handshake flags of a full-speed device controller
// Assumes: protocol engine gives one-cycle event pulses on this clock
// Notes:   register reads answer one cycle after the read strobe
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "uesf_consts.svh"

module uesf_flags (
  input  wire logic                    ref_clk_in,
  input  wire logic                    rst_b_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [7:0]              reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [7:0]              reg_rdata_out,
  input  wire uesf_pkg::uesf_link_evt_t evt_in,
  input  wire logic [2:0]              ask_ep_in,
  output uesf_pkg::uesf_link_ans_t     ans_out,
  output logic                         ep_irq_out
);

  // ************************************************************
  // state
  // ************************************************************
  logic [7:0]  status_ff  [`UESF_EP_COUNT];
  logic [7:0]  nxt_status [`UESF_EP_COUNT];
  logic [7:0]  irq_flags_ff;
  logic [7:0]  nxt_irq_flags;
  logic [7:0]  irq_en_ff;
  logic [15:0] ep_cfg_ff;
  logic [2:0]  sel_ff;
  logic [7:0]  reg_rdata_ff;
  logic [10:0] count_rd;

  function automatic uesf_pkg::uesf_ep_type_t ep_type(input logic [15:0] cfg,
                                                       input logic [2:0]  ep);
    ep_type = uesf_pkg::uesf_ep_type_t'(cfg[{ep, 1'b0} +: 2]);
  endfunction

  // ************************************************************
  // decode
  // ************************************************************
  wire wr_sel    = reg_wr_in && (reg_addr_in == `UESF_OFS_SELECTOR);
  wire wr_status = reg_wr_in && (reg_addr_in == `UESF_OFS_STATUS);
  wire wr_ien    = reg_wr_in && (reg_addr_in == `UESF_OFS_IRQ_ENABLE);
  wire wr_cfg    = reg_wr_in && (reg_addr_in == `UESF_OFS_EP_CONFIG);
  wire wr_iflag  = reg_wr_in && (reg_addr_in == `UESF_OFS_IRQ_FLAGS);
  wire evt_iso   = (ep_type(ep_cfg_ff, evt_in.ep) == uesf_pkg::UESF_EP_ISO);
  wire sel_iso   = (ep_type(ep_cfg_ff, sel_ff) == uesf_pkg::UESF_EP_ISO);
  wire ask_iso   = (ep_type(ep_cfg_ff, ask_ep_in) == uesf_pkg::UESF_EP_ISO);
  // iso crc bit cannot be cleared by firmware, so it must not keep the flag up
  wire [7:0] clr_mask = sel_iso ? (`UESF_SF_MASK & ~(8'h01 << `UESF_BIT_STL_CRC))
                                : `UESF_SF_MASK;
  wire [7:0] ask_st = status_ff[ask_ep_in];
  wire ask_bank_full = ask_st[`UESF_BIT_OUT_B0] || ask_st[`UESF_BIT_OUT_B1];
  wire evt_bank_busy = evt_in.out_bank ? status_ff[evt_in.ep][`UESF_BIT_OUT_B1]
                                       : status_ff[evt_in.ep][`UESF_BIT_OUT_B0];
  // a non-iso out event while the bank is held is a nak'ed packet: no count, no flag
  wire out_take  = evt_in.out_stored && (evt_iso || !evt_bank_busy);
  // setup always stores, even over a held out bank
  wire count_we  = out_take || evt_in.setup_ok;

  // ************************************************************
  // link answer
  // ************************************************************
  assign ans_out.stall    = ask_st[`UESF_BIT_STALL_RQ];
  assign ans_out.nak_out  = !ask_iso && ask_bank_full;
  assign ans_out.in_ready = ask_st[`UESF_BIT_IN_READY];
  assign ans_out.dir_in   = ask_st[`UESF_BIT_DIR];

  // ************************************************************
  // flag update; hardware set wins over a firmware clear
  // ************************************************************
  always_comb begin
    nxt_irq_flags = irq_flags_ff;
    for (int e = 0; e < `UESF_EP_COUNT; e++) begin
      nxt_status[e] = status_ff[e];
      if (wr_status && sel_ff == e[2:0]) begin
        // firmware owned bits follow the write, hardware set bits only clear
        nxt_status[e] = (reg_wdata_in & ~`UESF_SF_MASK)
                      | (status_ff[e] & reg_wdata_in & `UESF_SF_MASK);
        if (sel_iso) begin
          nxt_status[e][`UESF_BIT_STL_CRC] = status_ff[e][`UESF_BIT_STL_CRC];
        end
        // flag drops once firmware has cleared every hardware bit; events below win
        if ((nxt_status[e] & clr_mask) == 8'h00) begin
          nxt_irq_flags[e] = 1'b0;
        end
      end
      if (evt_in.ep == e[2:0]) begin
        if (evt_in.setup_ok) begin
          nxt_status[e] = 8'h04;
          nxt_irq_flags[e] = 1'b1;
        end else begin
          if (out_take) begin
            nxt_status[e][evt_in.out_bank ? `UESF_BIT_OUT_B1 : `UESF_BIT_OUT_B0] = 1'b1;
            nxt_irq_flags[e] = 1'b1;
            if (evt_iso) begin
              nxt_status[e][`UESF_BIT_STL_CRC] = evt_in.crc_error;
            end
          end
          if ((evt_in.in_sent && evt_iso) || (evt_in.in_acked && !evt_iso)) begin
            nxt_status[e][`UESF_BIT_IN_READY] = 1'b0;
            nxt_irq_flags[e] = 1'b1;
          end
          if (evt_in.in_acked && !evt_iso) begin
            nxt_status[e][`UESF_BIT_IN_DONE] = 1'b1;
          end
          if (evt_in.stall_sent && !evt_iso) begin
            nxt_status[e][`UESF_BIT_STL_CRC] = 1'b1;
            nxt_irq_flags[e] = 1'b1;
          end
        end
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (int e = 0; e < `UESF_EP_COUNT; e++) begin
        status_ff[e] <= `UESF_STATUS_RESET;
      end
      irq_flags_ff <= 8'h00;
    end else begin
      status_ff    <= nxt_status;
      irq_flags_ff <= nxt_irq_flags;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_en_ff <= 8'h00;
      ep_cfg_ff <= 16'h0000;
      sel_ff    <= 3'h0;
    end else begin
      if (wr_ien) irq_en_ff <= reg_wdata_in;
      if (wr_cfg) ep_cfg_ff <= {ep_cfg_ff[7:0], reg_wdata_in};
      if (wr_sel) sel_ff <= reg_wdata_in[2:0];
    end
  end

  // interrupt flag register is read only; the write decode is kept for clarity
  wire unused_iflag = wr_iflag;

  // only enabled endpoints reach the interrupt line
  assign ep_irq_out = |(irq_flags_ff & irq_en_ff);

  // ************************************************************
  // byte count store
  // ************************************************************
  uesf_count_mem u_count (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .wr_en_in   (count_we),
    .wr_addr_in (evt_in.ep),
    .wr_data_in (evt_in.byte_count),
    .rd_addr_in (sel_ff),
    .rd_data_out(count_rd)
  );

  // ************************************************************
  // read port: mem read data are already one cycle late, so the count
  // reads come straight from it; all others are registered here
  // ************************************************************
  logic rd_count_lo_ff;
  logic rd_count_hi_ff;

  wire [7:0] rd_mux =
    (reg_addr_in == `UESF_OFS_SELECTOR)   ? {5'h00, sel_ff} :
    (reg_addr_in == `UESF_OFS_STATUS)     ? status_ff[sel_ff] :
    (reg_addr_in == `UESF_OFS_IRQ_FLAGS)  ? irq_flags_ff :
    (reg_addr_in == `UESF_OFS_IRQ_ENABLE) ? irq_en_ff :
    (reg_addr_in == `UESF_OFS_EP_CONFIG)  ? ep_cfg_ff[7:0] : 8'h00;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_ff   <= 8'h00;
      rd_count_lo_ff <= 1'b0;
      rd_count_hi_ff <= 1'b0;
    end else begin
      reg_rdata_ff   <= reg_rd_in ? rd_mux : 8'h00;
      rd_count_lo_ff <= reg_rd_in && (reg_addr_in == `UESF_OFS_BYTE_LOW);
      rd_count_hi_ff <= reg_rd_in && (reg_addr_in == `UESF_OFS_BYTE_HIGH);
    end
  end

  assign reg_rdata_out = rd_count_lo_ff ? count_rd[7:0] :
                         rd_count_hi_ff ? {5'h00, count_rd[10:8]} :
                         reg_rdata_ff;

  // ************************************************************
  // checks
  // ************************************************************
  property p_setup_clears;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    evt_in.setup_ok |=> status_ff[$past(evt_in.ep)] == 8'h04 && irq_flags_ff[$past(evt_in.ep)];
  endproperty
  a_setup_clears: assert property (p_setup_clears) else $error("setup view wrong");

  property p_nak_b0;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (evt_in.out_stored && !evt_in.setup_ok && !evt_in.out_bank && evt_bank_busy && !evt_iso)
      |-> !count_we && (ask_ep_in != evt_in.ep || ans_out.nak_out);
  endproperty
  a_nak_b0: assert property (p_nak_b0) else $error("held bank not nak'ed");

  property p_stall;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (wr_status && reg_wdata_in[`UESF_BIT_STALL_RQ] && !(evt_in.setup_ok && evt_in.ep == sel_ff))
      |=> status_ff[$past(sel_ff)][`UESF_BIT_STALL_RQ] &&
          (ask_ep_in != $past(sel_ff) || ans_out.stall);
  endproperty
  a_stall: assert property (p_stall) else $error("stall answer wrong");

  property p_irq_gate;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (irq_en_ff == 8'h00) |-> !ep_irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("masked irq seen");

  property p_ack_done;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (evt_in.in_acked && !evt_in.setup_ok && !evt_iso)
      |=> status_ff[$past(evt_in.ep)][`UESF_BIT_IN_DONE] && irq_flags_ff[$past(evt_in.ep)];
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("in done not set");

  property p_ready_clr;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (evt_in.in_acked && !evt_iso) |=> !status_ff[$past(evt_in.ep)][`UESF_BIT_IN_READY];
  endproperty
  a_ready_clr: assert property (p_ready_clr) else $error("ready not cleared");

  property p_stall_sent;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (evt_in.stall_sent && !evt_in.setup_ok && !evt_iso)
      |=> status_ff[$past(evt_in.ep)][`UESF_BIT_STL_CRC];
  endproperty
  a_stall_sent: assert property (p_stall_sent) else $error("stall sent lost");

  property p_hi_zero;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in == `UESF_OFS_BYTE_HIGH) |=> reg_rdata_out[7:3] == 5'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("reserved bits set");

  // ************************************************************
  // multi-step checks; the first three are built from named event sequences
  // ************************************************************
  sequence s_out_b0_taken;
    out_take && !evt_in.setup_ok && !evt_in.out_bank;
  endsequence

  sequence s_out_b1_taken;
    out_take && !evt_in.setup_ok && evt_in.out_bank;
  endsequence

  sequence s_iso_sent;
    evt_in.in_sent && evt_iso && !evt_in.setup_ok;
  endsequence

  property p_out_b0;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    s_out_b0_taken
      |=> status_ff[$past(evt_in.ep)][`UESF_BIT_OUT_B0] && irq_flags_ff[$past(evt_in.ep)];
  endproperty
  a_out_b0: assert property (p_out_b0) else $error("bank 0 flag not set");

  property p_out_b1;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    s_out_b1_taken
      |=> status_ff[$past(evt_in.ep)][`UESF_BIT_OUT_B1] && irq_flags_ff[$past(evt_in.ep)];
  endproperty
  a_out_b1: assert property (p_out_b1) else $error("bank 1 flag not set");

  property p_iso_ready;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    s_iso_sent
      |=> !status_ff[$past(evt_in.ep)][`UESF_BIT_IN_READY] && irq_flags_ff[$past(evt_in.ep)];
  endproperty
  a_iso_ready: assert property (p_iso_ready) else $error("iso ready not cleared");

  property p_iso_crc;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (out_take && evt_iso && !evt_in.setup_ok)
      |=> status_ff[$past(evt_in.ep)][`UESF_BIT_STL_CRC] == $past(evt_in.crc_error);
  endproperty
  a_iso_crc: assert property (p_iso_crc) else $error("iso crc flag stale");

  property p_iso_ro;
    @(posedge ref_clk_in) disable iff (!rst_b_in)
    (wr_status && sel_iso && !(evt_in.ep == sel_ff && (evt_in.setup_ok || evt_in.out_stored)))
      |=> status_ff[$past(sel_ff)][`UESF_BIT_STL_CRC] ==
          $past(status_ff[sel_ff][`UESF_BIT_STL_CRC]);
  endproperty
  a_iso_ro: assert property (p_iso_ro) else $error("iso crc flag written");

endmodule // uesf_flags

// >>> rtl/uesf_pkg.sv
// Purpose: types of the endpoint status flag block
// Assumes: used with uesf_consts.svh
// Notes:   nothing here holds a number
package uesf_pkg;

  typedef enum logic [1:0] {
    UESF_EP_CONTROL,
    UESF_EP_ISO,
    UESF_EP_BULK,
    UESF_EP_INTERRUPT
  } uesf_ep_type_t;

  // one link event, pulses from the protocol engine
  typedef struct packed {
    logic [2:0]  ep;
    logic        setup_ok;
    logic        out_stored;
    logic        out_bank;
    logic        crc_error;
    logic        in_sent;
    logic        in_acked;
    logic        stall_sent;
    logic [10:0] byte_count;
  } uesf_link_evt_t;

  // answer to the protocol engine for the endpoint it asks about
  typedef struct packed {
    logic stall;
    logic nak_out;
    logic in_ready;
    logic dir_in;
  } uesf_link_ans_t;

endpackage : uesf_pkg

// >>> tb/test_usb_endpoint_status_flags.sv
// Purpose: register level test of the endpoint status flag block
// Assumes: host model drives link events, bench plays the firmware
// Notes:   ep types: 0,4 control; 1,5 iso; 2,6 bulk; 3,7 interrupt
`timescale 1ns/1ps
`include "uesf_consts.svh"

module test_usb_endpoint_status_flags;
  logic                     ref_clk_in;
  logic                     rst_b_in;
  logic                     reg_wr_in;
  logic                     reg_rd_in;
  logic [7:0]               reg_addr_in;
  logic [7:0]               reg_wdata_in;
  logic [7:0]               reg_rdata_out;
  logic [2:0]               ask_ep_in;
  logic                     ep_irq_out;
  uesf_pkg::uesf_link_evt_t evt_in;
  uesf_pkg::uesf_link_ans_t ans_out;
  int                       error_cnt;
  int                       n_tests;

  uesf_flags dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .evt_in(evt_in), .ask_ep_in(ask_ep_in),
    .ans_out(ans_out), .ep_irq_out(ep_irq_out));
  uesf_host_model host (.ans_in(ans_out), .ref_clk_in(ref_clk_in), .evt_out(evt_in),
    .ask_ep_out(ask_ep_in));

  // ************************************************************
  // firmware access tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    check({8'h00, reg_rdata_out}, {8'h00, exp});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ************************************************************
  // clock, reset, watchdog
  // ************************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    final_report;
  end

  initial begin
    rst_b_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rd(`UESF_OFS_STATUS, 8'h00);
    rd(`UESF_OFS_BYTE_HIGH, 8'h00);
    rd(`UESF_OFS_IRQ_FLAGS, 8'h00);
    rd(8'h00, 8'h00);
    wr(`UESF_OFS_EP_CONFIG, 8'he4);
    wr(`UESF_OFS_EP_CONFIG, 8'he4);
    rd(`UESF_OFS_EP_CONFIG, 8'he4);
    wr(`UESF_OFS_IRQ_ENABLE, 8'h01);
    $display("test reset and config done");
    // control endpoint 0
    wr(`UESF_OFS_SELECTOR, 8'h00);
    wr(`UESF_OFS_STATUS, 8'hb0);
    rd(`UESF_OFS_STATUS, 8'hb0);
    host.look(3'h0);
    check({12'h000, ans_out}, 16'h000b);
    host.out_pkt(3'h0, 1'b0, 1'b0, 11'h123);
    rd(`UESF_OFS_STATUS, 8'hb2);
    check({15'h0000, ep_irq_out}, 16'h0001);
    host.setup(3'h0, 11'h5a7);
    rd(`UESF_OFS_STATUS, 8'h04);
    rd(`UESF_OFS_BYTE_LOW, 8'ha7);
    rd(`UESF_OFS_BYTE_HIGH, 8'h05);
    rd(`UESF_OFS_IRQ_FLAGS, 8'h01);
    wr(`UESF_OFS_IRQ_ENABLE, 8'h00);
    check({15'h0000, ep_irq_out}, 16'h0000);
    wr(`UESF_OFS_IRQ_ENABLE, 8'h01);
    wr(`UESF_OFS_STATUS, 8'h4f);
    rd(`UESF_OFS_STATUS, 8'h04);
    wr(`UESF_OFS_STATUS, 8'h00);
    rd(`UESF_OFS_STATUS, 8'h00);
    rd(`UESF_OFS_IRQ_FLAGS, 8'h00);
    $display("test control endpoint done");
    // bulk endpoint 2, held banks and in/stall handshakes
    wr(`UESF_OFS_SELECTOR, 8'h02);
    host.out_pkt(3'h2, 1'b0, 1'b0, 11'h040);
    host.look(3'h2);
    check({12'h000, ans_out}, 16'h0004);
    host.out_pkt(3'h2, 1'b0, 1'b0, 11'h7ff);
    rd(`UESF_OFS_BYTE_LOW, 8'h40);
    host.out_pkt(3'h2, 1'b1, 1'b0, 11'h3c5);
    rd(`UESF_OFS_STATUS, 8'h42);
    rd(`UESF_OFS_BYTE_HIGH, 8'h03);
    rd(`UESF_OFS_BYTE_LOW, 8'hc5);
    wr(`UESF_OFS_STATUS, 8'h40);
    rd(`UESF_OFS_STATUS, 8'h40);
    host.look(3'h2);
    check({12'h000, ans_out}, 16'h0004);
    wr(`UESF_OFS_STATUS, 8'h10);
    host.look(3'h2);
    check({12'h000, ans_out}, 16'h0002);
    host.in_xfer(3'h2, 1'b0);
    rd(`UESF_OFS_STATUS, 8'h01);
    rd(`UESF_OFS_IRQ_FLAGS, 8'h04);
    check({15'h0000, ep_irq_out}, 16'h0000);
    wr(`UESF_OFS_STATUS, 8'h20);
    host.in_xfer(3'h2, 1'b0);
    rd(`UESF_OFS_STATUS, 8'h28);
    wr(`UESF_OFS_STATUS, 8'h20);
    rd(`UESF_OFS_STATUS, 8'h20);
    wr(`UESF_OFS_STATUS, 8'h00);
    $display("test bulk endpoint done");
    // iso endpoint 1: crc flag is read only and no nak on held bank
    wr(`UESF_OFS_SELECTOR, 8'h01);
    host.out_pkt(3'h1, 1'b0, 1'b1, 11'h011);
    rd(`UESF_OFS_STATUS, 8'h0a);
    wr(`UESF_OFS_STATUS, 8'h02);
    rd(`UESF_OFS_STATUS, 8'h0a);
    host.out_pkt(3'h1, 1'b0, 1'b0, 11'h022);
    rd(`UESF_OFS_STATUS, 8'h02);
    rd(`UESF_OFS_BYTE_LOW, 8'h22);
    wr(`UESF_OFS_STATUS, 8'h1a);
    rd(`UESF_OFS_STATUS, 8'h12);
    host.in_xfer(3'h1, 1'b1);
    rd(`UESF_OFS_STATUS, 8'h02);
    wr(`UESF_OFS_SELECTOR, 8'h00);
    rd(`UESF_OFS_BYTE_HIGH, 8'h05);
    rd(`UESF_OFS_BYTE_LOW, 8'ha7);
    $display("test iso endpoint and selector done");
    final_report;
  end
endmodule // test_usb_endpoint_status_flags

// >>> tb/uesf_host_model.sv
// Purpose: host side model that drives link events into the flag block
// Assumes: one-cycle event pulses, answers read combinationally
// Notes:   out packets are always sent, so the block itself must drop held banks
`timescale 1ns/1ps

module uesf_host_model (
  input  wire uesf_pkg::uesf_link_ans_t ans_in,
  input  wire logic                     ref_clk_in,
  output uesf_pkg::uesf_link_evt_t      evt_out,
  output logic [2:0]                    ask_ep_out
);
  // ************************************************************
  // event pulses
  // ************************************************************
  initial begin
    evt_out = '0;
    ask_ep_out = 3'h0;
  end

  task automatic pulse(input uesf_pkg::uesf_link_evt_t e);
    @(posedge ref_clk_in);
    evt_out <= e;
    @(posedge ref_clk_in);
    evt_out <= '0;
  endtask

  task automatic look(input logic [2:0] ep);
    @(posedge ref_clk_in);
    ask_ep_out <= ep;
    #1;
  endtask

  task automatic setup(input logic [2:0] ep, input logic [10:0] cnt);
    uesf_pkg::uesf_link_evt_t e;
    e = '0;
    e.ep = ep;
    e.setup_ok = 1'b1;
    e.byte_count = cnt;
    pulse(e);
  endtask

  task automatic out_pkt(input logic [2:0] ep, input logic bank, input logic crc,
                         input logic [10:0] cnt);
    uesf_pkg::uesf_link_evt_t e;
    e = '0;
    e.ep = ep;
    e.out_stored = 1'b1;
    e.out_bank = bank;
    e.crc_error = crc;
    e.byte_count = cnt;
    pulse(e);
  endtask

  // stall wins over a ready packet, as the answer is a stall handshake
  task automatic in_xfer(input logic [2:0] ep, input logic iso);
    uesf_pkg::uesf_link_evt_t e;
    e = '0;
    e.ep = ep;
    look(ep);
    if (ans_in.stall) begin
      e.stall_sent = 1'b1;
      pulse(e);
    end else if (ans_in.in_ready) begin
      e.in_sent = 1'b1;
      pulse(e);
      if (!iso) begin
        e.in_sent = 1'b0;
        e.in_acked = 1'b1;
        pulse(e);
      end
    end
  endtask
endmodule // uesf_host_model
